// File: data_space_operand_addressing_tb_top.sv
`timescale 1ns/1ps
module data_space_operand_addressing_tb_top import dsa_pkg::*;;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic req_i, ptr_sel_i, post_dec_i, done_o, bit_o;
    dsa_mode_t mode_i;
    dsa_op_t op_i;
    logic [2:0] bit_sel_i;
    logic [7:0] dir_addr_i, imm_i, acc_i, rdata_o, eff_addr_o, ptr_b_o, ptr_x_o, sp_o;
    logic [7:0] port_f_pins_i, port_l_pins_i, port_g_pins_i, port_c_pins_i;
    logic [7:0] port_f_data_o, port_f_cfg_o, port_l_data_o, port_l_cfg_o, port_g_data_o, port_g_cfg_o;
    logic [7:0] port_c_data_o, port_c_cfg_o, port_d_data_o;
    logic [7:0] small_rdata;
    int error_cnt = 0;
    int comparisons = 0;
    logic [7:0] rw [28] = '{8'h94, 8'h95, 8'hC7, 8'hC8, 8'hC9, 8'hCA, 8'hD0, 8'hD1, 8'hD4, 8'hD5, 8'hD8,
        8'hD9, 8'hDC, 8'hE6, 8'hE7, 8'hE8, 8'hE9, 8'hEA, 8'hEB, 8'hEC, 8'hED, 8'hEE, 8'hEF, 8'hF0, 8'hFB,
        8'h00, 8'h6F, 8'hFC};
    logic [7:0] res [14] = '{8'h80, 8'h93, 8'h97, 8'hA0, 8'hC6, 8'hCB, 8'hCF, 8'hD3, 8'hD7, 8'hDB, 8'hDD,
        8'hDF, 8'hE0, 8'hE5};
    ////////////////////////////////////////////////////////////////////////
    // 25 MHz clock
    always #20 clk_i = ~clk_i;
    dsa_core_model dsa_core_model_i (.clk_i, .req_o(req_i), .mode_o(mode_i), .op_o(op_i),
        .ptr_sel_o(ptr_sel_i), .post_dec_o(post_dec_i), .addr_o(dir_addr_i), .imm_o(imm_i),
        .bit_sel_o(bit_sel_i), .acc_o(acc_i));
    dsa_top dsa_top_i (.clk_i, .rst_n_i, .req_i, .mode_i, .op_i, .ptr_sel_i, .post_dec_i, .dir_addr_i,
        .imm_i, .bit_sel_i, .acc_i, .port_f_pins_i, .port_l_pins_i, .port_g_pins_i, .port_c_pins_i,
        .done_o, .rdata_o, .bit_o, .eff_addr_o, .ptr_b_o, .ptr_x_o, .sp_o, .port_f_data_o, .port_f_cfg_o,
        .port_l_data_o, .port_l_cfg_o, .port_g_data_o, .port_g_cfg_o, .port_c_data_o, .port_c_cfg_o,
        .port_d_data_o);
    // small ram variant on the same requests
    dsa_top #(.LARGE_RAM(1'b0)) dsa_top_small_i (.clk_i, .rst_n_i, .req_i, .mode_i, .op_i, .ptr_sel_i,
        .post_dec_i, .dir_addr_i, .imm_i, .bit_sel_i, .acc_i, .port_f_pins_i, .port_l_pins_i, .port_g_pins_i,
        .port_c_pins_i, .done_o(), .rdata_o(small_rdata), .bit_o(), .eff_addr_o(), .ptr_b_o(), .ptr_x_o(),
        .sp_o(), .port_f_data_o(), .port_f_cfg_o(), .port_l_data_o(), .port_l_cfg_o(), .port_g_data_o(),
        .port_g_cfg_o(), .port_c_data_o(), .port_c_cfg_o(), .port_d_data_o());
    ////////////////////////////////////////////////////////////////////////
    // compares and closing
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk8
    task automatic chk1(input string what, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask : chk1
    task automatic finish_test;
        $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test
    // one access; a held one leaves the next call to follow back to back
    task automatic acc(input dsa_mode_t m, input dsa_op_t o, input logic [7:0] a, input logic [7:0] d,
                       input logic s = 1'b0, input logic dec = 1'b0, input logic [2:0] b = 3'h0,
                       input bit hold = 1'b0);
        dsa_core_model_i.issue(m, o, a, d, s, dec, b, hold);
        if (!hold) begin
            #1;
            chk1("done", 1'b1, done_o);
            @(posedge clk_i);
        end
    endtask : acc
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        acc(DSA_MODE_DIRECT, DSA_OP_STORE, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        acc(DSA_MODE_DIRECT, DSA_OP_LOAD, a, 8'h00);
        chk8("rdata", exp, rdata_o);
        chk8("eff_addr", a, eff_addr_o);
    endtask : rd
    ////////////////////////////////////////////////////////////////////////
    // hang guard, far beyond the roughly 150 accesses below
    initial begin
        #200000;
        error_cnt++;
        finish_test();
    end
    // main sequence
    initial begin
        {port_f_pins_i, port_l_pins_i, port_g_pins_i, port_c_pins_i} = {8'h3C, 8'hA5, 8'h5A, 8'hC3};
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        #1;
        chk8("sp", 8'h6F, sp_o);
        @(posedge clk_i);
        foreach (rw[i]) rd(rw[i], 8'h00);
        foreach (rw[i]) wr(rw[i], rw[i] ^ 8'h5A);
        foreach (res[i]) wr(res[i], 8'hFF);
        foreach (res[i]) rd(res[i], 8'h00);
        foreach (rw[i]) rd(rw[i], rw[i] ^ 8'h5A);
        chk8("pf_data", 8'h94 ^ 8'h5A, port_f_data_o);
        chk8("pf_cfg", 8'h95 ^ 8'h5A, port_f_cfg_o);
        chk8("pl_data", 8'hD0 ^ 8'h5A, port_l_data_o);
        chk8("pl_cfg", 8'hD1 ^ 8'h5A, port_l_cfg_o);
        chk8("pg_data", 8'hD4 ^ 8'h5A, port_g_data_o);
        chk8("pg_cfg", 8'hD5 ^ 8'h5A, port_g_cfg_o);
        chk8("pc_data", 8'hD8 ^ 8'h5A, port_c_data_o);
        chk8("pc_cfg", 8'hD9 ^ 8'h5A, port_c_cfg_o);
        chk8("pd_data", 8'hDC ^ 8'h5A, port_d_data_o);
        // pins are read-only, unused bytes read all ones
        wr(8'h96, 8'h00);
        rd(8'h96, 8'h3C);
        rd(8'hD2, 8'hA5);
        rd(8'hD6, 8'h5A);
        rd(8'hDA, 8'hC3);
        wr(8'h70, 8'h12);
        rd(8'h70, 8'hFF);
        wr(8'h7F, 8'h34);
        rd(8'h7F, 8'hFF);
        // small variant: ram only at 02..2F, the rest of the low segment reads all ones
        wr(8'h2F, 8'h77);
        rd(8'h2F, 8'h77);
        chk8("small_2f", 8'h77, small_rdata);
        rd(8'h02, 8'h00);
        chk8("small_02", 8'h00, small_rdata);
        rd(8'h00, 8'h5A);
        chk8("small_00", 8'hFF, small_rdata);
        rd(8'h30, 8'h00);
        chk8("small_30", 8'hFF, small_rdata);
        // pointer modes
        wr(8'h05, 8'h62);
        wr(8'h21, 8'h44);
        wr(8'hFE, 8'h05);
        wr(8'hFC, 8'h21);
        acc(DSA_MODE_INDIR, DSA_OP_LOAD, 8'h00, 8'h00, 1'b1);
        chk8("ind_x", 8'h44, rdata_o);
        acc(DSA_MODE_INDIR, DSA_OP_LOAD, 8'h00, 8'h00);
        chk8("ind_b", 8'h62, rdata_o);
        acc(DSA_MODE_POSTMOD, DSA_OP_XCHG, 8'h00, 8'h03);
        chk8("xchg", 8'h62, rdata_o);
        chk8("ptr_b", 8'h06, ptr_b_o);
        rd(8'h05, 8'h03);
        acc(DSA_MODE_POSTMOD, DSA_OP_LOAD, 8'h00, 8'h00, 1'b1, 1'b1);
        chk8("pm_x", 8'h44, rdata_o);
        chk8("ptr_x", 8'h20, ptr_x_o);
        acc(DSA_MODE_DIRECT, DSA_OP_XCHG, 8'h10, 8'h9A, 1'b0, 1'b0, 3'h0, 1'b1);
        rd(8'h10, 8'h9A);
        acc(DSA_MODE_IMM, DSA_OP_LOAD, 8'h00, 8'h05);
        chk8("imm", 8'h05, rdata_o);
        acc(DSA_MODE_IMM_SHORT, DSA_OP_LOAD, 8'h00, 8'hA7);
        chk8("ptr_b", 8'h07, ptr_b_o);
        rd(8'hFE, 8'h07);
        // bit set, clear and test on port, ram and pins
        acc(DSA_MODE_DIRECT, DSA_OP_SETB, 8'hD0, 8'h00, 1'b0, 1'b0, 3'h0);
        chk8("setb", 8'h8B, port_l_data_o);
        acc(DSA_MODE_DIRECT, DSA_OP_CLRB, 8'hD0, 8'h00, 1'b0, 1'b0, 3'h7);
        chk8("clrb", 8'h0B, port_l_data_o);
        acc(DSA_MODE_DIRECT, DSA_OP_TESTB, 8'hD0, 8'h00, 1'b0, 1'b0, 3'h3);
        chk1("testb", 1'b1, bit_o);
        acc(DSA_MODE_DIRECT, DSA_OP_TESTB, 8'h96, 8'h00, 1'b0, 1'b0, 3'h0);
        chk1("testb", 1'b0, bit_o);
        acc(DSA_MODE_DIRECT, DSA_OP_SETB, 8'hF0, 8'h00, 1'b0, 1'b0, 3'h0);
        rd(8'hF0, 8'hAB);
        finish_test();
    end
endmodule : data_space_operand_addressing_tb_top
bind dsa_top dsa_checker dsa_checker_i (.clk_i, .rst_n_i, .req_i, .mode_i, .op_i, .ptr_sel_i, .post_dec_i,
    .dir_addr_i, .imm_i, .acc_i, .done_o, .rdata_o, .eff_addr_o, .ptr_b_o, .ptr_x_o, .sp_o);

// File: dsa_checker.sv
`timescale 1ns/1ps
module dsa_checker
    import dsa_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic req_i,
    input wire dsa_mode_t mode_i,
    input wire dsa_op_t op_i,
    input wire logic ptr_sel_i,
    input wire logic post_dec_i,
    input wire logic [7:0] dir_addr_i,
    input wire logic [7:0] imm_i,
    input wire logic [7:0] acc_i,
    input wire logic done_o,
    input wire logic [7:0] rdata_o,
    input wire logic [7:0] eff_addr_o,
    input wire logic [7:0] ptr_b_o,
    input wire logic [7:0] ptr_x_o,
    input wire logic [7:0] sp_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    ////////////////////////////////////////////////////////////////////////
    // pointer chosen by the request and short immediate value
    logic [7:0] sel_ptr;
    logic [7:0] imm_lo;
    assign sel_ptr = ptr_sel_i ? ptr_x_o : ptr_b_o;
    assign imm_lo = {4'h0, imm_i[3:0]};
    // exchange on a ram byte, then a load of the same byte
    sequence s_xchg;
        req_i && op_i == DSA_OP_XCHG && mode_i == DSA_MODE_DIRECT && dir_addr_i < 8'h70;
    endsequence
    sequence s_reload;
        req_i && op_i == DSA_OP_LOAD && mode_i == DSA_MODE_DIRECT && $stable(dir_addr_i);
    endsequence
    ////////////////////////////////////////////////////////////////////////
    a_done_pulse: assert property (done_o == $past(req_i))
        else $error("done not one cycle after request");
    a_sp_reset: assert property ($rose(rst_n_i) |-> sp_o == 8'h6F)
        else $error("stack pointer reset value");
    a_direct_addr: assert property (req_i && mode_i == DSA_MODE_DIRECT |=> eff_addr_o == $past(dir_addr_i))
        else $error("direct address altered");
    a_indir_addr: assert property (req_i && mode_i inside {DSA_MODE_INDIR, DSA_MODE_POSTMOD}
        |=> eff_addr_o == $past(sel_ptr)) else $error("indirect address wrong");
    a_postmod_step: assert property (req_i && mode_i == DSA_MODE_POSTMOD && !ptr_sel_i
        |=> ptr_b_o == ($past(post_dec_i) ? $past(ptr_b_o) - 8'h01 : $past(ptr_b_o) + 8'h01))
        else $error("pointer step wrong");
    a_imm_value: assert property (req_i && mode_i == DSA_MODE_IMM |=> rdata_o == $past(imm_i))
        else $error("immediate value wrong");
    a_imm_short: assert property (req_i && mode_i == DSA_MODE_IMM_SHORT |=> ptr_b_o == $past(imm_lo))
        else $error("short immediate pointer wrong");
    a_unused_ones: assert property (req_i && op_i == DSA_OP_LOAD && mode_i == DSA_MODE_DIRECT
        && dir_addr_i[7:4] == 4'h7 |=> rdata_o == 8'hFF) else $error("unused byte not all ones");
    a_xchg_reload: assert property (s_xchg ##1 s_reload |=> rdata_o == $past(acc_i, 2))
        else $error("exchange did not store accumulator");
endmodule : dsa_checker

// File: dsa_consts.svh
`ifndef DSA_CONSTS_SVH
`define DSA_CONSTS_SVH

////////////////////////////////////////////////////////////////////////
// on-chip ram windows
`define DSA_RAM_SMALL_LO 8'h02
`define DSA_RAM_SMALL_HI 8'h2F
`define DSA_RAM_LARGE_LO 8'h00
`define DSA_RAM_LARGE_HI 8'h6F
`define DSA_LOW_SEG_END 8'h80
`define DSA_RAM_DEPTH 112
`define DSA_REGRAM_LO 8'hF0
`define DSA_REGRAM_HI 8'hFB
`define DSA_REGRAM_DEPTH 12

////////////////////////////////////////////////////////////////////////
// pointer registers
`define DSA_ADDR_PTR_X 8'hFC
`define DSA_ADDR_SP 8'hFD
`define DSA_ADDR_PTR_B 8'hFE

////////////////////////////////////////////////////////////////////////
// port registers
`define DSA_ADDR_PF_DATA 8'h94
`define DSA_ADDR_PF_CFG 8'h95
`define DSA_ADDR_PF_PINS 8'h96
`define DSA_ADDR_PL_DATA 8'hD0
`define DSA_ADDR_PL_CFG 8'hD1
`define DSA_ADDR_PL_PINS 8'hD2
`define DSA_ADDR_PG_DATA 8'hD4
`define DSA_ADDR_PG_CFG 8'hD5
`define DSA_ADDR_PG_PINS 8'hD6
`define DSA_ADDR_PC_DATA 8'hD8
`define DSA_ADDR_PC_CFG 8'hD9
`define DSA_ADDR_PC_PINS 8'hDA
`define DSA_ADDR_PD_DATA 8'hDC

////////////////////////////////////////////////////////////////////////
// monitor, wakeup, timer and control registers
`define DSA_ADDR_TMO_SERVICE 8'hC7
`define DSA_ADDR_WK_EDGE 8'hC8
`define DSA_ADDR_WK_ENABLE 8'hC9
`define DSA_ADDR_WK_PENDING 8'hCA
`define DSA_ADDR_RLD2_LO 8'hE6
`define DSA_ADDR_RLD2_HI 8'hE7
`define DSA_ADDR_INT_CTRL 8'hE8
`define DSA_ADDR_SHIFT 8'hE9
`define DSA_ADDR_TCNT_LO 8'hEA
`define DSA_ADDR_TCNT_HI 8'hEB
`define DSA_ADDR_RLD1_LO 8'hEC
`define DSA_ADDR_RLD1_HI 8'hED
`define DSA_ADDR_TS_CTRL 8'hEE
`define DSA_ADDR_PSW 8'hEF

////////////////////////////////////////////////////////////////////////
// reset and fixed read values
`define DSA_SP_RESET 8'h6F
`define DSA_PTR_RESET 8'h00
`define DSA_UNUSED_READ 8'hFF
`define DSA_RESERVED_READ 8'h00

`endif

// File: dsa_core_model.sv
`timescale 1ns/1ps
module dsa_core_model
    import dsa_pkg::*;
(
    input wire logic clk_i,
    output logic req_o,
    output dsa_mode_t mode_o,
    output dsa_op_t op_o,
    output logic ptr_sel_o,
    output logic post_dec_o,
    output logic [7:0] addr_o,
    output logic [7:0] imm_o,
    output logic [2:0] bit_sel_o,
    output logic [7:0] acc_o
);
    // idle before the first request
    initial begin
        req_o = 1'b0;
        mode_o = DSA_MODE_DIRECT;
        op_o = DSA_OP_LOAD;
        {ptr_sel_o, post_dec_o, addr_o, imm_o, bit_sel_o, acc_o} = '0;
    end
    // one request: raised at an edge, held to the taking edge
    task automatic issue(input dsa_mode_t m, input dsa_op_t o, input logic [7:0] a, input logic [7:0] d,
                         input logic s, input logic dec, input logic [2:0] b, input bit hold);
        req_o <= 1'b1;
        mode_o <= m;
        op_o <= o;
        ptr_sel_o <= s;
        post_dec_o <= dec;
        addr_o <= a;
        imm_o <= d;
        bit_sel_o <= b;
        acc_o <= d;
        @(posedge clk_i);
        if (!hold) begin
            req_o <= 1'b0;
            // released address and accumulator lines do not keep the last value
            addr_o <= ~a;
            acc_o <= ~d;
        end
    endtask : issue
endmodule : dsa_core_model

// File: dsa_pkg.sv
package dsa_pkg;

    // operand addressing modes
    typedef enum logic [2:0] {
        DSA_MODE_DIRECT = 3'h0,
        DSA_MODE_INDIR = 3'h1,
        DSA_MODE_POSTMOD = 3'h2,
        DSA_MODE_IMM = 3'h3,
        DSA_MODE_IMM_SHORT = 3'h4
    } dsa_mode_t;

    // operations on the addressed operand
    typedef enum logic [2:0] {
        DSA_OP_LOAD = 3'h0,
        DSA_OP_STORE = 3'h1,
        DSA_OP_XCHG = 3'h2,
        DSA_OP_SETB = 3'h3,
        DSA_OP_CLRB = 3'h4,
        DSA_OP_TESTB = 3'h5
    } dsa_op_t;

endpackage : dsa_pkg

// File: dsa_ram.sv
`timescale 1ns/1ps
module dsa_ram #(
    parameter int DEPTH = 16,
    parameter int IW = $clog2(DEPTH)
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic we_i,
    input wire logic [IW-1:0] idx_i,
    input wire logic [7:0] wdata_i,
    output logic [DEPTH-1:0][7:0] mem_o
);

    typedef struct packed {
        logic [DEPTH-1:0][7:0] mem;
    } dsa_ram_st_t;

    dsa_ram_st_t st;
    dsa_ram_st_t next_st;

    // byte write at the index, reads are the whole array
    always_comb begin
        next_st = st;
        if (we_i && (32'(idx_i) < DEPTH)) begin
            next_st.mem[idx_i] = wdata_i;
        end
    end

    // storage flops
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign mem_o = st.mem;

endmodule : dsa_ram

// File: dsa_sync.sv
`timescale 1ns/1ps
module dsa_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } dsa_sync_st_t;

    dsa_sync_st_t st;
    dsa_sync_st_t next_st;

    // two stages, first stage read only by the second
    always_comb begin
        next_st.meta = async_i;
        next_st.stable = st.meta;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sync_o = st.stable;

endmodule : dsa_sync

// File: dsa_top.sv
`timescale 1ns/1ps
`include "dsa_consts.svh"
module dsa_top
    import dsa_pkg::*;
#(
    parameter bit LARGE_RAM = 1'b1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic req_i,
    input wire dsa_mode_t mode_i,
    input wire dsa_op_t op_i,
    input wire logic ptr_sel_i,
    input wire logic post_dec_i,
    input wire logic [7:0] dir_addr_i,
    input wire logic [7:0] imm_i,
    input wire logic [2:0] bit_sel_i,
    input wire logic [7:0] acc_i,
    input wire logic [7:0] port_f_pins_i,
    input wire logic [7:0] port_l_pins_i,
    input wire logic [7:0] port_g_pins_i,
    input wire logic [7:0] port_c_pins_i,
    output logic done_o,
    output logic [7:0] rdata_o,
    output logic bit_o,
    output logic [7:0] eff_addr_o,
    output logic [7:0] ptr_b_o,
    output logic [7:0] ptr_x_o,
    output logic [7:0] sp_o,
    output logic [7:0] port_f_data_o,
    output logic [7:0] port_f_cfg_o,
    output logic [7:0] port_l_data_o,
    output logic [7:0] port_l_cfg_o,
    output logic [7:0] port_g_data_o,
    output logic [7:0] port_g_cfg_o,
    output logic [7:0] port_c_data_o,
    output logic [7:0] port_c_cfg_o,
    output logic [7:0] port_d_data_o
);

    ////////////////////////////////////////////////////////////////////
    // peripheral bank layout
    localparam int BANK_DEPTH = 23;
    localparam logic [4:0] IX_PF_DATA = 5'h00;
    localparam logic [4:0] IX_PF_CFG = 5'h01;
    localparam logic [4:0] IX_TMO = 5'h02;
    localparam logic [4:0] IX_WK_EDGE = 5'h03;
    localparam logic [4:0] IX_WK_EN = 5'h04;
    localparam logic [4:0] IX_WK_PND = 5'h05;
    localparam logic [4:0] IX_PL_DATA = 5'h06;
    localparam logic [4:0] IX_PL_CFG = 5'h07;
    localparam logic [4:0] IX_PG_DATA = 5'h08;
    localparam logic [4:0] IX_PG_CFG = 5'h09;
    localparam logic [4:0] IX_PC_DATA = 5'h0A;
    localparam logic [4:0] IX_PC_CFG = 5'h0B;
    localparam logic [4:0] IX_PD_DATA = 5'h0C;
    localparam logic [4:0] IX_RLD2_LO = 5'h0D;
    localparam logic [4:0] IX_RLD2_HI = 5'h0E;
    localparam logic [4:0] IX_INT_CTRL = 5'h0F;
    localparam logic [4:0] IX_SHIFT = 5'h10;
    localparam logic [4:0] IX_TCNT_LO = 5'h11;
    localparam logic [4:0] IX_TCNT_HI = 5'h12;
    localparam logic [4:0] IX_RLD1_LO = 5'h13;
    localparam logic [4:0] IX_RLD1_HI = 5'h14;
    localparam logic [4:0] IX_TS_CTRL = 5'h15;
    localparam logic [4:0] IX_PSW = 5'h16;

    typedef struct packed {
        logic [7:0] ptr_b;
        logic [7:0] ptr_x;
        logic [7:0] sp;
        logic done;
        logic [7:0] rdata;
        logic bit_res;
        logic [7:0] eff_addr;
    } dsa_core_st_t;

    localparam dsa_core_st_t ST_RESET = '{
        ptr_b: `DSA_PTR_RESET,
        ptr_x: `DSA_PTR_RESET,
        sp: `DSA_SP_RESET,
        done: 1'b0,
        rdata: 8'h00,
        bit_res: 1'b0,
        eff_addr: 8'h00
    };

    dsa_core_st_t st;
    dsa_core_st_t next_st;

    logic [7:0] eff_addr;
    logic [7:0] ptr_cur;
    logic [7:0] rd_val;
    logic [7:0] wr_val;
    logic [7:0] bit_mask;
    logic mem_access;
    logic wr_en;
    logic ram_hit;
    logic regram_hit;
    logic bank_hit;
    logic [4:0] bank_idx;
    logic [31:0] pins_sync;
    logic [`DSA_RAM_DEPTH-1:0][7:0] ram_mem;
    logic [`DSA_REGRAM_DEPTH-1:0][7:0] regram_mem;
    logic [BANK_DEPTH-1:0][7:0] bank_mem;

    ////////////////////////////////////////////////////////////////////
    // address decode helpers

    // ram window depends on the ram size variant
    function automatic logic dsa_is_ram(input logic [7:0] a);
        if (LARGE_RAM) begin
            return (a <= `DSA_RAM_LARGE_HI);
        end else begin
            return (a >= `DSA_RAM_SMALL_LO) && (a <= `DSA_RAM_SMALL_HI);
        end
    endfunction : dsa_is_ram

    // read/write peripheral registers, hit flag then bank index
    function automatic logic [5:0] dsa_bank_map(input logic [7:0] a);
        case (a)
            `DSA_ADDR_PF_DATA: return {1'b1, IX_PF_DATA};
            `DSA_ADDR_PF_CFG: return {1'b1, IX_PF_CFG};
            `DSA_ADDR_TMO_SERVICE: return {1'b1, IX_TMO};
            `DSA_ADDR_WK_EDGE: return {1'b1, IX_WK_EDGE};
            `DSA_ADDR_WK_ENABLE: return {1'b1, IX_WK_EN};
            `DSA_ADDR_WK_PENDING: return {1'b1, IX_WK_PND};
            `DSA_ADDR_PL_DATA: return {1'b1, IX_PL_DATA};
            `DSA_ADDR_PL_CFG: return {1'b1, IX_PL_CFG};
            `DSA_ADDR_PG_DATA: return {1'b1, IX_PG_DATA};
            `DSA_ADDR_PG_CFG: return {1'b1, IX_PG_CFG};
            `DSA_ADDR_PC_DATA: return {1'b1, IX_PC_DATA};
            `DSA_ADDR_PC_CFG: return {1'b1, IX_PC_CFG};
            `DSA_ADDR_PD_DATA: return {1'b1, IX_PD_DATA};
            `DSA_ADDR_RLD2_LO: return {1'b1, IX_RLD2_LO};
            `DSA_ADDR_RLD2_HI: return {1'b1, IX_RLD2_HI};
            `DSA_ADDR_INT_CTRL: return {1'b1, IX_INT_CTRL};
            `DSA_ADDR_SHIFT: return {1'b1, IX_SHIFT};
            `DSA_ADDR_TCNT_LO: return {1'b1, IX_TCNT_LO};
            `DSA_ADDR_TCNT_HI: return {1'b1, IX_TCNT_HI};
            `DSA_ADDR_RLD1_LO: return {1'b1, IX_RLD1_LO};
            `DSA_ADDR_RLD1_HI: return {1'b1, IX_RLD1_HI};
            `DSA_ADDR_TS_CTRL: return {1'b1, IX_TS_CTRL};
            `DSA_ADDR_PSW: return {1'b1, IX_PSW};
            default: return 6'h00;
        endcase
    endfunction : dsa_bank_map

    ////////////////////////////////////////////////////////////////////
    // pin inputs from outside the clock domain
    dsa_sync #(
        .WIDTH(32)
    ) u_pin_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .async_i({port_c_pins_i, port_g_pins_i, port_l_pins_i, port_f_pins_i}),
        .sync_o(pins_sync)
    );

    ////////////////////////////////////////////////////////////////////
    // effective address and access class
    always_comb begin
        ptr_cur = ptr_sel_i ? st.ptr_x : st.ptr_b;
        case (mode_i)
            DSA_MODE_DIRECT: eff_addr = dir_addr_i;
            DSA_MODE_INDIR: eff_addr = ptr_cur;
            DSA_MODE_POSTMOD: eff_addr = ptr_cur;
            default: eff_addr = 8'h00;
        endcase
        mem_access = req_i && ((mode_i == DSA_MODE_DIRECT) || (mode_i == DSA_MODE_INDIR)
            || (mode_i == DSA_MODE_POSTMOD));
        ram_hit = dsa_is_ram(eff_addr);
        regram_hit = (eff_addr >= `DSA_REGRAM_LO) && (eff_addr <= `DSA_REGRAM_HI);
        {bank_hit, bank_idx} = dsa_bank_map(eff_addr);
    end

    ////////////////////////////////////////////////////////////////////
    // read mux over the whole data space
    always_comb begin
        if (ram_hit) begin
            rd_val = ram_mem[eff_addr[6:0]];
        end else if (eff_addr < `DSA_LOW_SEG_END) begin
            rd_val = `DSA_UNUSED_READ;
        end else if (regram_hit) begin
            rd_val = regram_mem[eff_addr[3:0]];
        end else if (bank_hit) begin
            rd_val = bank_mem[bank_idx];
        end else begin
            case (eff_addr)
                `DSA_ADDR_PTR_X: rd_val = st.ptr_x;
                `DSA_ADDR_SP: rd_val = st.sp;
                `DSA_ADDR_PTR_B: rd_val = st.ptr_b;
                `DSA_ADDR_PF_PINS: rd_val = pins_sync[7:0];
                `DSA_ADDR_PL_PINS: rd_val = pins_sync[15:8];
                `DSA_ADDR_PG_PINS: rd_val = pins_sync[23:16];
                `DSA_ADDR_PC_PINS: rd_val = pins_sync[31:24];
                default: rd_val = `DSA_RESERVED_READ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // write value: plain store, exchange, or read-modify-write of one bit
    always_comb begin
        bit_mask = 8'h01 << bit_sel_i;
        wr_en = 1'b0;
        wr_val = rd_val;
        case (op_i)
            DSA_OP_STORE: begin
                wr_en = mem_access;
                wr_val = acc_i;
            end
            DSA_OP_XCHG: begin
                wr_en = mem_access;
                wr_val = acc_i;
            end
            DSA_OP_SETB: begin
                wr_en = mem_access;
                wr_val = rd_val | bit_mask;
            end
            DSA_OP_CLRB: begin
                wr_en = mem_access;
                wr_val = rd_val & ~bit_mask;
            end
            default: begin
                wr_en = 1'b0;
                wr_val = rd_val;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // storage; writes to unused, read-only and reserved slots go nowhere
    dsa_ram #(
        .DEPTH(`DSA_RAM_DEPTH)
    ) u_main_ram (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .we_i(wr_en && ram_hit),
        .idx_i(eff_addr[6:0]),
        .wdata_i(wr_val),
        .mem_o(ram_mem)
    );

    dsa_ram #(
        .DEPTH(`DSA_REGRAM_DEPTH)
    ) u_reg_ram (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .we_i(wr_en && regram_hit),
        .idx_i(eff_addr[3:0]),
        .wdata_i(wr_val),
        .mem_o(regram_mem)
    );

    dsa_ram #(
        .DEPTH(BANK_DEPTH)
    ) u_periph_bank (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .we_i(wr_en && bank_hit),
        .idx_i(bank_idx),
        .wdata_i(wr_val),
        .mem_o(bank_mem)
    );

    ////////////////////////////////////////////////////////////////////
    // pointers, result and completion
    always_comb begin
        next_st = st;
        next_st.done = req_i;
        if (req_i) begin
            next_st.eff_addr = eff_addr;
            next_st.bit_res = 1'b0;
        end
        // pointer registers written as data addresses
        if (wr_en) begin
            case (eff_addr)
                `DSA_ADDR_PTR_X: next_st.ptr_x = wr_val;
                `DSA_ADDR_SP: next_st.sp = wr_val;
                `DSA_ADDR_PTR_B: next_st.ptr_b = wr_val;
                default: next_st.sp = next_st.sp;
            endcase
        end
        // operand value handed back to the core
        if (mem_access) begin
            case (op_i)
                DSA_OP_LOAD: next_st.rdata = rd_val;
                DSA_OP_XCHG: next_st.rdata = rd_val;
                DSA_OP_TESTB: begin
                    next_st.rdata = rd_val;
                    next_st.bit_res = rd_val[bit_sel_i];
                end
                default: next_st.rdata = st.rdata;
            endcase
        end
        if (req_i && (mode_i == DSA_MODE_IMM)) begin
            next_st.rdata = imm_i;
        end
        if (req_i && (mode_i == DSA_MODE_IMM_SHORT)) begin
            next_st.ptr_b = {4'h0, imm_i[3:0]};
            next_st.rdata = {4'h0, imm_i[3:0]};
        end
        // step after the access, overrides a write to the same pointer
        if (req_i && (mode_i == DSA_MODE_POSTMOD)) begin
            if (ptr_sel_i) begin
                next_st.ptr_x = post_dec_i ? st.ptr_x - 8'h01 : st.ptr_x + 8'h01;
            end else begin
                next_st.ptr_b = post_dec_i ? st.ptr_b - 8'h01 : st.ptr_b + 8'h01;
            end
        end
    end

    // state register
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= ST_RESET;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs, all from flops
    assign done_o = st.done;
    assign rdata_o = st.rdata;
    assign bit_o = st.bit_res;
    assign eff_addr_o = st.eff_addr;
    assign ptr_b_o = st.ptr_b;
    assign ptr_x_o = st.ptr_x;
    assign sp_o = st.sp;
    assign port_f_data_o = bank_mem[IX_PF_DATA];
    assign port_f_cfg_o = bank_mem[IX_PF_CFG];
    assign port_l_data_o = bank_mem[IX_PL_DATA];
    assign port_l_cfg_o = bank_mem[IX_PL_CFG];
    assign port_g_data_o = bank_mem[IX_PG_DATA];
    assign port_g_cfg_o = bank_mem[IX_PG_CFG];
    assign port_c_data_o = bank_mem[IX_PC_DATA];
    assign port_c_cfg_o = bank_mem[IX_PC_CFG];
    assign port_d_data_o = bank_mem[IX_PD_DATA];

endmodule : dsa_top
